// *** logic/uss_pkg.sv ***
package uss_pkg;
  // Suspend control states
  typedef enum logic [1:0] {
    USS_UNCONF,
    USS_ACTIVE,
    USS_SUSP,
    USS_WAKE
  } uss_state_e;

  // Remote wakeup resume drive time in microseconds
  localparam int unsigned RESUME_DRIVE_US  = 2000;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned RESUME_DRIVE_CYC = RESUME_DRIVE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 20;
endpackage : uss_pkg

// *** logic/uss_suspend_ctrl.sv ***
module uss_suspend_ctrl
  import uss_pkg::*;
#(
  parameter int unsigned RESUME_CYC = RESUME_DRIVE_CYC
) (
  // Clock, reset, enable
  input  wire logic MCLK_IN,
  input  wire logic RESETN_IN,
  input  wire logic CE_IN,
  // Bus condition detectors
  input  wire logic BUS_SUSPEND_IN,
  input  wire logic BUS_RESUME_IN,
  input  wire logic BUS_RESET_IN,
  // Enumeration status
  input  wire logic CONFIGURED_IN,
  input  wire logic REMOTE_WAKE_EN_IN,
  // Wake request pin, active low
  input  wire logic WAKE_REQ_N_IN,
  // Outputs
  output logic      SLEEP_INDICATOR_OUT,
  output logic      SLEEP_INDICATOR_LOW_OUT,
  output logic      DRIVE_RESUME_OUT,
  output logic      SUSPENDED_OUT
);

  uss_state_e       state_reg;
  uss_state_e       state_next;
  logic [CNT_W-1:0] wake_cnt_reg;
  logic             wake_done;

  assign wake_done = (wake_cnt_reg == CNT_W'(RESUME_CYC - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      USS_UNCONF: begin
        if (BUS_RESET_IN) begin
          state_next = USS_UNCONF;
        end else if (BUS_SUSPEND_IN) begin
          state_next = USS_SUSP;
        end else if (CONFIGURED_IN) begin
          state_next = USS_ACTIVE;
        end
      end
      USS_ACTIVE: begin
        if (BUS_RESET_IN) begin
          state_next = USS_UNCONF;
        end else if (BUS_SUSPEND_IN) begin
          state_next = USS_SUSP;
        end else if (!CONFIGURED_IN) begin
          state_next = USS_UNCONF;
        end
      end
      USS_SUSP: begin
        if (BUS_RESET_IN) begin
          state_next = USS_UNCONF;
        end else if (BUS_RESUME_IN) begin
          state_next = CONFIGURED_IN ? USS_ACTIVE : USS_UNCONF;
        end else if (REMOTE_WAKE_EN_IN && !WAKE_REQ_N_IN) begin
          state_next = USS_WAKE;
        end
      end
      USS_WAKE: begin
        if (BUS_RESET_IN) begin
          state_next = USS_UNCONF;
        end else if (wake_done) begin
          state_next = CONFIGURED_IN ? USS_ACTIVE : USS_UNCONF;
        end
      end
      default: state_next = USS_UNCONF;
    endcase
  end

  // State, reset to unconfigured
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= USS_UNCONF;
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  // Resume drive timer
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wake_cnt_reg <= '0;
    end else if (CE_IN) begin
      if (state_reg == USS_WAKE && !wake_done) begin
        wake_cnt_reg <= wake_cnt_reg + CNT_W'(1);
      end else begin
        wake_cnt_reg <= '0;
      end
    end
  end

  // Outputs from flops
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SLEEP_INDICATOR_OUT     <= 1'b1;
      SLEEP_INDICATOR_LOW_OUT <= 1'b0;
      DRIVE_RESUME_OUT        <= 1'b0;
      SUSPENDED_OUT           <= 1'b0;
    end else if (CE_IN) begin
      SLEEP_INDICATOR_OUT     <= (state_next != USS_ACTIVE);
      SLEEP_INDICATOR_LOW_OUT <= (state_next == USS_ACTIVE);
      DRIVE_RESUME_OUT        <= (state_next == USS_WAKE);
      SUSPENDED_OUT           <= (state_next == USS_SUSP) || (state_next == USS_WAKE);
    end
  end

  a_low_complement: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    SLEEP_INDICATOR_LOW_OUT == !SLEEP_INDICATOR_OUT)
    else $error("sleep indicators not complementary");

  a_suspend_enter: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && BUS_SUSPEND_IN && !BUS_RESET_IN && state_reg != USS_SUSP
      && state_reg != USS_WAKE |=> SUSPENDED_OUT)
    else $error("suspend not entered");

  a_suspend_ind: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    SUSPENDED_OUT |-> SLEEP_INDICATOR_OUT)
    else $error("indicator low while suspended");

  a_unconf_ind: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_reg == USS_UNCONF |-> SLEEP_INDICATOR_OUT)
    else $error("indicator low while unconfigured");

  a_resume_exit: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && BUS_RESUME_IN |=> !SUSPENDED_OUT)
    else $error("resume did not end suspend");

  a_busreset_exit: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && BUS_RESET_IN |=> !SUSPENDED_OUT && state_reg == USS_UNCONF)
    else $error("bus reset did not end suspend");

  a_wake_gate: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && !REMOTE_WAKE_EN_IN && !BUS_RESUME_IN
      && !BUS_RESET_IN |=> state_reg == USS_SUSP)
    else $error("wake pin acted while disabled");

  a_exit_deassert: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    $fell(SUSPENDED_OUT) && CONFIGURED_IN && state_reg == USS_ACTIVE
      |-> !SLEEP_INDICATOR_OUT)
    else $error("indicator held after suspend exit");

  a_wake_drive: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && REMOTE_WAKE_EN_IN && !WAKE_REQ_N_IN
      && !BUS_RESUME_IN && !BUS_RESET_IN |=> DRIVE_RESUME_OUT && SUSPENDED_OUT)
    else $error("resume not driven on wake");

  a_cfg_active: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_UNCONF && CONFIGURED_IN && !BUS_SUSPEND_IN && !BUS_RESET_IN
      |=> state_reg == USS_ACTIVE && !SLEEP_INDICATOR_OUT)
    else $error("configuration did not release indicators");

  a_active_ind: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_reg == USS_ACTIVE |-> !SLEEP_INDICATOR_OUT && SLEEP_INDICATOR_LOW_OUT && !SUSPENDED_OUT)
    else $error("indicators asserted while active");

  a_drive_in_wake: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    DRIVE_RESUME_OUT |-> state_reg == USS_WAKE && SUSPENDED_OUT)
    else $error("resume driven outside wake");

  a_wake_hold: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_WAKE && !BUS_RESET_IN && !wake_done
      |=> DRIVE_RESUME_OUT && SUSPENDED_OUT)
    else $error("resume drive cut short");

  a_wake_finish: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_WAKE && !BUS_RESET_IN && wake_done
      |=> !DRIVE_RESUME_OUT && !SUSPENDED_OUT)
    else $error("suspend held after resume drive");

  a_wake_fresh: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    $rose(DRIVE_RESUME_OUT) |-> wake_cnt_reg == '0)
    else $error("resume timer not cleared at wake");

  a_ce_freeze: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    !CE_IN |=> $stable(state_reg) && $stable(wake_cnt_reg) && $stable(SLEEP_INDICATOR_OUT)
      && $stable(SUSPENDED_OUT) && $stable(DRIVE_RESUME_OUT))
    else $error("state moved while clock enable low");

  a_susp_stay: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && !BUS_RESET_IN && !BUS_RESUME_IN
      && !(REMOTE_WAKE_EN_IN && !WAKE_REQ_N_IN) |=> SUSPENDED_OUT && !DRIVE_RESUME_OUT)
    else $error("suspend left without cause");

  a_unconf_resume: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && BUS_RESUME_IN && !BUS_RESET_IN && !CONFIGURED_IN
      |=> SLEEP_INDICATOR_OUT && !SUSPENDED_OUT)
    else $error("indicator released while unconfigured");

  a_active_drop: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_ACTIVE && !CONFIGURED_IN && !BUS_SUSPEND_IN
      |=> state_reg == USS_UNCONF && SLEEP_INDICATOR_OUT)
    else $error("indicator low after configuration lost");

  a_resume_first: assert property (
    @(posedge MCLK_IN) disable iff (!RESETN_IN)
    CE_IN && state_reg == USS_SUSP && BUS_RESUME_IN && REMOTE_WAKE_EN_IN && !WAKE_REQ_N_IN
      |=> !DRIVE_RESUME_OUT && !SUSPENDED_OUT)
    else $error("wake pin beat bus resume");

endmodule : uss_suspend_ctrl

// *** tb/usb_suspend_state_control_tb_top.sv ***
module usb_suspend_state_control_tb_top;
  import uss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 8;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, cfg = 1'b0, rwe = 1'b0, wkn = 1'b1;
  logic [1:0] cmd = 2'h0;
  logic bs, br, bx, ind, lowi, drv, susp;
  logic [31:0] seed = 32'h5866;
  int miscompares = 0, cmp_count = 0, n, k, ms = 0, mc = 0;
  always #2.5 clk = ~clk;
  uss_host_model host (.cmd_in(cmd), .suspend_out(bs), .resume_out(br), .reset_out(bx));
  uss_suspend_ctrl #(.RESUME_CYC(RC)) dut (.MCLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce),
    .BUS_SUSPEND_IN(bs), .BUS_RESUME_IN(br), .BUS_RESET_IN(bx), .CONFIGURED_IN(cfg),
    .REMOTE_WAKE_EN_IN(rwe), .WAKE_REQ_N_IN(wkn), .SLEEP_INDICATOR_OUT(ind),
    .SLEEP_INDICATOR_LOW_OUT(lowi), .DRIVE_RESUME_OUT(drv), .SUSPENDED_OUT(susp));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %b saw %b", nm, e, s);
    end
  endtask : chk
  task automatic step(input logic [1:0] c, input logic w, input logic f, input logic r);
    @(posedge clk);
    cmd <= c;
    wkn <= w;
    cfg <= f;
    rwe <= r;
    @(posedge clk);
    #1;
  endtask : step
  task automatic expo(input logic s, input logic i, input logic d);
    chk("susp", s, susp);
    chk("ind", i, ind);
    chk("low", ~i, lowi);
    chk("drv", d, drv);
  endtask : expo
  // Expected state after one edge
  task automatic model_edge();
    if (ce) begin
      if (ms == 3) mc++;
      if (cmd == 2'h3) ms = 0;
      else if (ms < 2) ms = (cmd == 2'h1) ? 2 : (cfg ? 1 : 0);
      else if (ms == 2 && cmd == 2'h2) ms = cfg ? 1 : 0;
      else if (ms == 2 && rwe && !wkn) ms = 3;
      else if (ms == 3 && mc == RC) ms = cfg ? 1 : 0;
      if (ms != 3) mc = 0;
    end
  endtask : model_edge
  task automatic report_and_stop();
    $display("cmp %0d bad %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    step(2'h0, 1'b1, 1'b0, 1'b1);
    expo(1'b0, 1'b1, 1'b0);
    for (k = 0; k < 3; k++) begin
      step(2'h0, 1'b1, 1'b1, 1'b1);
      expo(1'b0, 1'b0, 1'b0);
      step(2'h1, 1'b1, 1'b1, 1'b1);
      expo(1'b1, 1'b1, 1'b0);
      if (k == 0) begin
        step(2'h2, 1'b1, 1'b1, 1'b1);
        expo(1'b0, 1'b0, 1'b0);
      end else if (k == 1) begin
        step(2'h3, 1'b1, 1'b1, 1'b1);
        expo(1'b0, 1'b1, 1'b0);
      end else begin
        step(2'h0, 1'b0, 1'b1, 1'b0);
        expo(1'b1, 1'b1, 1'b0);
        step(2'h0, 1'b0, 1'b1, 1'b1);
        chk("drv", 1'b1, drv);
        chk("susp", 1'b1, susp);
        n = 0;
        while (n < 20 && drv === 1'b1) begin
          @(posedge clk);
          wkn <= 1'b1;
          #1;
          n++;
        end
        chk("hold", 1'b1, n == RC);
        expo(1'b0, 1'b0, 1'b0);
      end
      $display("end exit case %0d", k);
    end
    step(2'h1, 1'b1, 1'b1, 1'b1);
    expo(1'b1, 1'b1, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    expo(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    $display("end device reset");
    repeat (300) begin
      @(posedge clk);
      model_edge();
      seed = xs(seed);
      {ce, cfg, rwe, wkn, cmd} <= {seed[6] | seed[5], seed[4:0]};
      #1;
      chk("low", ~ind, lowi);
      expo(ms >= 2, ms != 1, ms == 3);
    end
    $display("end random");
    report_and_stop();
  end
endmodule : usb_suspend_state_control_tb_top

// *** tb/uss_host_model.sv ***
module uss_host_model (
  // Bus condition command
  input  wire logic [1:0] cmd_in,
  // Bus condition outputs
  output logic            suspend_out,
  output logic            resume_out,
  output logic            reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host places one bus condition at a time
  assign suspend_out = (cmd_in == 2'h1);
  assign resume_out  = (cmd_in == 2'h2);
  assign reset_out   = (cmd_in == 2'h3);
endmodule : uss_host_model
